//--- uart_tx_defs.svh
// Register offsets, field positions, reset values and divider counts of the transmitter.
`ifndef UART_TX_DEFS_SVH
`define UART_TX_DEFS_SVH

// ==========================================================================
// Register byte offsets
`define UTX_DATA_OFS 8'h00
`define UTX_CSA_OFS 8'h04
`define UTX_CSB_OFS 8'h08
`define UTX_CSC_OFS 8'h0c
`define UTX_DIV_OFS 8'h10

// ==========================================================================
// Field positions
`define UTX_CSA_EMPTY 0
`define UTX_CSA_DONE 1
`define UTX_CSA_DSPEED 2
`define UTX_CSA_BUSY 3
`define UTX_CSB_TX_ENABLE 0
`define UTX_CSB_BEIE 1
`define UTX_CSB_TDIE 2
`define UTX_CSB_NINTH 3
`define UTX_CSC_CSZ_LSB 0
`define UTX_CSC_PAREN 4
`define UTX_CSC_PARODD 5
`define UTX_CSC_STOP2 6
`define UTX_CSC_SYNC 7
`define UTX_CSC_MASTER 8
`define UTX_CSC_CPOL 9

// ==========================================================================
// Reset values and divider counts
`define UTX_CSZ_RST 3'h3
`define UTX_DIV_RST 12'h000
`define UTX_CSZ_NINE 3'h7
`define UTX_PRE_NORMAL 5'h10
`define UTX_PRE_DOUBLE 5'h08

`endif

//--- uart_tx_pkg.sv
// Types shared by the transmitter modules.
package uart_tx_pkg;

  // ========================================================================
  // Frame engine states
  typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_PARITY, ST_STOP, ST_END} shift_state_t;

  // ========================================================================
  // Configuration carriers
  typedef struct packed {
    logic [2:0] char_size;
    logic parity_en;
    logic parity_odd;
    logic two_stop;
  } frame_cfg_t;

  typedef struct packed {
    logic sync_mode;
    logic sync_master;
    logic clock_pol;
    logic double_speed;
    logic [11:0] divisor;
  } clk_cfg_t;

  // ========================================================================
  // Module state
  typedef struct packed {
    shift_state_t state;
    logic [8:0] shreg;
    logic [3:0] bits_left;
    logic parity;
    logic stops_left;
    logic txd;
    logic done;
  } shift_st_t;

  typedef struct packed {
    logic [11:0] count;
    logic [3:0] prescale;
    logic xck;
    logic xck_in;
    logic xck_prev;
    logic bit_en;
  } baud_st_t;

  typedef struct packed {
    logic wb_ack;
    logic [31:0] wb_dat;
    logic buf_full;
    logic [8:0] buf_data;
    logic en;
    logic be_ie;
    logic td_ie;
    logic ninth;
    logic dspeed;
    frame_cfg_t fcfg;
    logic sync_mode;
    logic sync_master;
    logic cpol;
    logic [11:0] divisor;
    logic done_flag;
    logic active;
    logic irq_empty;
    logic irq_done;
    logic out;
    logic out_oe_n;
    logic xck_oe_n;
    logic reload;
  } tx_regs_t;

  // ========================================================================
  // Character size decoding
  function automatic logic [3:0] data_bits(input logic [2:0] csz);
    unique case (csz)
      3'h0: data_bits = 4'h5;
      3'h1: data_bits = 4'h6;
      3'h2: data_bits = 4'h7;
      3'h7: data_bits = 4'h9;
      default: data_bits = 4'h8;
    endcase
  endfunction

  function automatic logic [8:0] char_mask(input logic [2:0] csz);
    char_mask = 9'h1ff >> (4'h9 - data_bits(csz));
  endfunction

endpackage

//--- uart_baud_gen.sv
// Rate divider and sync clock handling that produce the one-cycle bit enable.
`timescale 1ns/1ps
`include "uart_tx_defs.svh"
module uart_baud_gen (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic en_i,
  input wire logic reload_i,
  input wire uart_tx_pkg::clk_cfg_t cfg_i,
  // Sync clock pin
  input wire logic xck_i,
  output logic xck_o,
  // Bit timing
  output logic bit_en_o
);
  uart_tx_pkg::baud_st_t q, d;
  logic tick;
  logic [3:0] pre_last;

  always_comb begin
    d = q;
    d.bit_en = 1'b0;
    tick = (q.count == 12'h000);
    d.count = (tick || reload_i) ? cfg_i.divisor : q.count - 12'h001;
    pre_last = cfg_i.double_speed ? 4'(`UTX_PRE_DOUBLE - 5'h01) : 4'(`UTX_PRE_NORMAL - 5'h01);
    d.xck_in = xck_i;
    d.xck_prev = q.xck_in;
    if (!en_i) begin
      d.prescale = 4'h0;
      d.xck = cfg_i.clock_pol;
    end else if (!cfg_i.sync_mode) begin
      if (tick) begin
        d.prescale = (q.prescale == pre_last) ? 4'h0 : q.prescale + 4'h1;
        d.bit_en = (q.prescale == pre_last);
      end
    end else if (cfg_i.sync_master) begin
      if (tick) begin
        d.xck = !q.xck;
        d.bit_en = (q.xck == cfg_i.clock_pol);
      end
    end else begin
      d.bit_en = (q.xck_in != q.xck_prev) && (q.xck_in != cfg_i.clock_pol);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign xck_o = q.xck;
  assign bit_en_o = q.bit_en;
endmodule // uart_baud_gen

//--- uart_tx_shift.sv
// Frame engine: shift register that sends start, data, parity and stop bits.
`timescale 1ns/1ps
module uart_tx_shift (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Timing and format
  input wire logic bit_en_i,
  input wire uart_tx_pkg::frame_cfg_t cfg_i,
  // Buffer side
  input wire logic load_i,
  input wire logic [8:0] data_i,
  output logic take_o,
  // Status and line
  output logic idle_o,
  output logic done_o,
  output logic txd_o
);
  uart_tx_pkg::shift_st_t q, d;
  logic take;

  always_comb begin
    d = q;
    d.done = 1'b0;
    take = (q.state == uart_tx_pkg::ST_IDLE) && load_i;
    if (bit_en_i) begin
      unique case (q.state)
        uart_tx_pkg::ST_IDLE: begin
          d.txd = 1'b1;
        end
        uart_tx_pkg::ST_START: begin
          d.txd = 1'b0;
          d.state = uart_tx_pkg::ST_DATA;
        end
        uart_tx_pkg::ST_DATA: begin
          d.txd = q.shreg[0];
          d.shreg = {1'b0, q.shreg[8:1]};
          d.bits_left = q.bits_left - 4'h1;
          if (q.bits_left == 4'h1) begin
            d.state = cfg_i.parity_en ? uart_tx_pkg::ST_PARITY : uart_tx_pkg::ST_STOP;
          end
        end
        uart_tx_pkg::ST_PARITY: begin
          d.txd = q.parity;
          d.state = uart_tx_pkg::ST_STOP;
        end
        uart_tx_pkg::ST_STOP: begin
          d.txd = 1'b1;
          d.stops_left = 1'b0;
          if (!q.stops_left) begin
            d.state = uart_tx_pkg::ST_END;
          end
        end
        uart_tx_pkg::ST_END: begin
          if (load_i) begin
            take = 1'b1;
            d.txd = 1'b0;
            d.state = uart_tx_pkg::ST_DATA;
          end else begin
            d.done = 1'b1;
            d.state = uart_tx_pkg::ST_IDLE;
          end
        end
      endcase
    end
    if (take) begin
      d.shreg = data_i;
      d.bits_left = uart_tx_pkg::data_bits(cfg_i.char_size);
      d.parity = (^data_i) ^ cfg_i.parity_odd;
      d.stops_left = cfg_i.two_stop;
      if (q.state == uart_tx_pkg::ST_IDLE) begin
        d.state = uart_tx_pkg::ST_START;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.txd <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign take_o = take;
  assign idle_o = (q.state == uart_tx_pkg::ST_IDLE);
  assign done_o = q.done;
  assign txd_o = q.txd;
endmodule // uart_tx_shift

//--- uart_transmitter.sv
// Serial transmitter with transmit buffer, flags, pin takeover and Wishbone registers.
`timescale 1ns/1ps
`include "uart_tx_defs.svh"
module uart_transmitter (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Interrupt requests
  input wire logic gie_i,
  input wire logic done_irq_ack_i,
  output logic irq_empty_o,
  output logic irq_done_o,
  // Serial output pin
  output logic serial_out_o,
  output logic serial_out_oe_n_o,
  // Sync clock pin
  input wire logic sync_clk_i,
  output logic sync_clk_o,
  output logic sync_clk_oe_n_o
);
  uart_tx_pkg::tx_regs_t q, d;
  uart_tx_pkg::clk_cfg_t clk_cfg;
  logic [31:0] m;
  logic wr;
  logic data_wr;
  logic take;
  logic shift_idle;
  logic shift_done;
  logic shift_txd;
  logic bit_en;
  logic xck_q;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [31:0] msk);
    merge = (old & ~msk) | (nw & msk);
  endfunction

  // ========================================================================
  // Bus decode
  assign m = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
  // Writes take effect on the ack edge, so a request held over two edges never writes twice.
  assign wr = cyc_i && stb_i && we_i && q.wb_ack;
  assign data_wr = wr && (adr_i == `UTX_DATA_OFS) && sel_i[0];
  assign clk_cfg = '{sync_mode: q.sync_mode, sync_master: q.sync_master, clock_pol: q.cpol,
                     double_speed: q.dspeed, divisor: q.divisor};

  // ========================================================================
  // Register file and control
  always_comb begin
    logic [31:0] csa;
    logic [31:0] csb;
    logic [31:0] csc;
    logic [31:0] nw;
    logic done_clr;
    csa = 32'h0;
    csb = 32'h0;
    csc = 32'h0;
    nw = 32'h0;
    done_clr = done_irq_ack_i;
    d = q;
    csa[`UTX_CSA_EMPTY] = !q.buf_full;
    csa[`UTX_CSA_DONE] = q.done_flag;
    csa[`UTX_CSA_DSPEED] = q.dspeed;
    csa[`UTX_CSA_BUSY] = !shift_idle;
    csb[`UTX_CSB_TX_ENABLE] = q.en;
    csb[`UTX_CSB_BEIE] = q.be_ie;
    csb[`UTX_CSB_TDIE] = q.td_ie;
    csb[`UTX_CSB_NINTH] = q.ninth;
    csc[`UTX_CSC_CSZ_LSB +: 3] = q.fcfg.char_size;
    csc[`UTX_CSC_PAREN] = q.fcfg.parity_en;
    csc[`UTX_CSC_PARODD] = q.fcfg.parity_odd;
    csc[`UTX_CSC_STOP2] = q.fcfg.two_stop;
    csc[`UTX_CSC_SYNC] = q.sync_mode;
    csc[`UTX_CSC_MASTER] = q.sync_master;
    csc[`UTX_CSC_CPOL] = q.cpol;

    // One wait state: ack comes the cycle after the request, read data with it.
    d.wb_ack = cyc_i && stb_i && !q.wb_ack;
    d.wb_dat = 32'h0;
    d.reload = 1'b0;
    if (cyc_i && stb_i && !q.wb_ack && !we_i) begin
      unique case (adr_i)
        `UTX_CSA_OFS: d.wb_dat = csa;
        `UTX_CSB_OFS: d.wb_dat = csb;
        `UTX_CSC_OFS: d.wb_dat = csc;
        `UTX_DIV_OFS: d.wb_dat = {20'h0, q.divisor};
        default: d.wb_dat = 32'h0;
      endcase
    end

    if (wr) begin
      unique case (adr_i)
        `UTX_CSA_OFS: begin
          nw = merge(csa, dat_i, m);
          d.dspeed = nw[`UTX_CSA_DSPEED];
          done_clr = done_clr || (m[`UTX_CSA_DONE] && dat_i[`UTX_CSA_DONE]);
        end
        `UTX_CSB_OFS: begin
          nw = merge(csb, dat_i, m);
          d.en = nw[`UTX_CSB_TX_ENABLE];
          d.be_ie = nw[`UTX_CSB_BEIE];
          d.td_ie = nw[`UTX_CSB_TDIE];
          d.ninth = nw[`UTX_CSB_NINTH];
        end
        `UTX_CSC_OFS: begin
          nw = merge(csc, dat_i, m);
          d.fcfg.char_size = nw[`UTX_CSC_CSZ_LSB +: 3];
          d.fcfg.parity_en = nw[`UTX_CSC_PAREN];
          d.fcfg.parity_odd = nw[`UTX_CSC_PARODD];
          d.fcfg.two_stop = nw[`UTX_CSC_STOP2];
          d.sync_mode = nw[`UTX_CSC_SYNC];
          d.sync_master = nw[`UTX_CSC_MASTER];
          d.cpol = nw[`UTX_CSC_CPOL];
        end
        `UTX_DIV_OFS: begin
          nw = merge({20'h0, q.divisor}, dat_i, m);
          d.divisor = nw[11:0];
          d.reload = 1'b1;
        end
        default: begin
          nw = 32'h0;
        end
      endcase
    end

    if (take) begin
      d.buf_full = 1'b0;
    end
    if (data_wr) begin
      d.buf_full = 1'b1;
      // A write while full overwrites the waiting character, so software polls the empty flag first.
      // mask and ninth bit
      d.buf_data = {q.ninth, dat_i[7:0]} & uart_tx_pkg::char_mask(q.fcfg.char_size);
    end

    d.done_flag = (q.done_flag && !done_clr) || shift_done;

    // The pin stays owned after tx_enable clears until nothing is left to send.
    // delayed disable
    d.active = q.en || (q.active && (q.buf_full || !shift_idle));

    d.irq_empty = gie_i && q.be_ie && !q.buf_full;
    d.irq_done = gie_i && q.td_ie && q.done_flag;

    // The pin outputs are registered, so the line lags the shifter by one clock.
    // pin takeover
    d.out = q.active ? shift_txd : 1'b1;
    d.out_oe_n = !q.active;
    d.xck_oe_n = !(q.active && q.sync_mode && q.sync_master);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q <= '0;
      q.fcfg.char_size <= `UTX_CSZ_RST;
      q.divisor <= `UTX_DIV_RST;
      q.out <= 1'b1;
      q.out_oe_n <= 1'b1;
      q.xck_oe_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ========================================================================
  // Bit timing and frame engine
  uart_baud_gen u_baud (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .en_i(q.active),
    .reload_i(q.reload),
    .cfg_i(clk_cfg),
    .xck_i(sync_clk_i),
    .xck_o(xck_q),
    .bit_en_o(bit_en)
  );

  uart_tx_shift u_shift (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .bit_en_i(bit_en),
    .cfg_i(q.fcfg),
    .load_i(q.buf_full && q.active),
    .data_i(q.buf_data),
    .take_o(take),
    .idle_o(shift_idle),
    .done_o(shift_done),
    .txd_o(shift_txd)
  );

  assign dat_o = q.wb_dat;
  assign ack_o = q.wb_ack;
  assign irq_empty_o = q.irq_empty;
  assign irq_done_o = q.irq_done;
  assign serial_out_o = q.out;
  assign serial_out_oe_n_o = q.out_oe_n;
  assign sync_clk_o = xck_q;
  assign sync_clk_oe_n_o = q.xck_oe_n;

  // ========================================================================
  // Assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_pin_takeover: assert property (q.active |=> !serial_out_oe_n_o) else $error("Serial pin not driven.");
  a_xck_takeover: assert property (q.active && q.sync_mode && q.sync_master |=> !sync_clk_oe_n_o)
    else $error("Sync clock pin not driven.");
  a_write_fills: assert property (data_wr |=> q.buf_full && !csa_empty_seen()) else $error("Write lost.");
  a_mask_bits: assert property (data_wr && q.fcfg.char_size == 3'h0 |=> q.buf_data[8:5] == 4'h0)
    else $error("Unused bits kept.");
  a_ninth_bit: assert property (data_wr && q.fcfg.char_size == `UTX_CSZ_NINE |=> q.buf_data[8] == $past(q.ninth))
    else $error("Ninth bit wrong.");
  a_take_empties: assert property (take && !data_wr |=> !q.buf_full) else $error("Buffer not emptied.");
  a_empty_irq: assert property (gie_i && q.be_ie && !q.buf_full |=> irq_empty_o) else $error("Empty irq missing.");
  a_done_set: assert property (shift_done |=> q.done_flag) else $error("Done flag not set.");
  a_done_irq: assert property (gie_i && q.td_ie && q.done_flag |=> irq_done_o) else $error("Done irq missing.");
  a_disable_wait: assert property (!q.en && q.active && !shift_idle |=> q.active) else $error("Early disable.");
  a_idle_high: assert property (q.active && shift_idle ##1 q.active |=> serial_out_o) else $error("Idle not high.");

  a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("Bus ack late.");
  a_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("Bus ack held.");
  a_read_idle: assert property (!ack_o |-> dat_o == 32'h0)
    else $error("Read data outside ack.");
  a_done_clear: assert property (done_irq_ack_i && !shift_done |=> !q.done_flag)
    else $error("Done flag not cleared.");
  a_pin_release: assert property (!q.active |=> serial_out_oe_n_o && serial_out_o)
    else $error("Serial pin still driven.");
  a_xck_release: assert property (!(q.active && q.sync_mode && q.sync_master) |=> sync_clk_oe_n_o)
    else $error("Sync clock pin still driven.");
  a_done_empty: assert property (shift_done |-> !$past(q.buf_full && q.active))
    else $error("Done with data pending.");
  a_irq_gated: assert property (!gie_i |=> !irq_empty_o && !irq_done_o)
    else $error("Interrupt without global enable.");
  a_empty_irq_off: assert property (!q.be_ie |=> !irq_empty_o)
    else $error("Empty irq without enable.");

  c_frame_done: cover property (shift_done ##1 irq_done_o);
  c_back_to_back: cover property (take && !shift_idle);
  c_disable_done: cover property (!q.en && q.active ##1 !q.active);
  c_nine_bit: cover property (data_wr && q.fcfg.char_size == `UTX_CSZ_NINE);
  c_sync_frame: cover property (shift_done && q.sync_mode && q.sync_master);

  function automatic logic csa_empty_seen();
    csa_empty_seen = !q.buf_full;
  endfunction
endmodule // uart_transmitter

//--- uart_rx_model.sv
// Behavioural serial receiver that decodes frames from the transmit line.
`timescale 1ns/1ps
module uart_rx_model (
  // Clock
  input wire logic clk_i,
  // Line and format
  input wire logic line_i,
  input wire logic [4:0] per_i,
  input wire logic [3:0] nbits_i,
  input wire logic par_en_i,
  input wire logic par_odd_i,
  input wire logic two_stop_i,
  // Received character, error flag on top
  output logic valid_o,
  output logic [9:0] word_o
);
  logic [8:0] d;
  logic bad;

  // ========================================================================
  // Frame decoder
  // start, data lsb first, stops
  initial begin
    valid_o = 1'b0;
    word_o = 10'h000;
    forever begin
      @(negedge line_i);
      repeat (per_i / 2) @(posedge clk_i);
      bad = line_i;
      d = 9'h000;
      for (int i = 0; i < nbits_i; i++) begin
        repeat (per_i) @(posedge clk_i);
        d[i] = line_i;
      end
      if (par_en_i) begin
        repeat (per_i) @(posedge clk_i);
        bad = bad | (line_i !== (^d ^ par_odd_i));
      end
      repeat (per_i) @(posedge clk_i);
      bad = bad | (line_i !== 1'b1);
      if (two_stop_i) begin
        repeat (per_i) @(posedge clk_i);
        bad = bad | (line_i !== 1'b1);
      end
      word_o <= {bad, d};
      valid_o <= 1'b1;
      @(posedge clk_i);
      valid_o <= 1'b0;
    end
  end
endmodule // uart_rx_model

//--- uart_transmitter_bench.sv
// Self-checking bench for the serial transmitter with a line-side receiver model.
`timescale 1ns/1ps
`include "uart_tx_defs.svh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin errors++; $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module uart_transmitter_bench;
  // ========================================================================
  // Signals
  logic clk_i, rst_i, cyc_i, stb_i, we_i, gie_i, done_irq_ack_i, sync_clk_i;
  logic [7:0] adr_i;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o, rd;
  logic ack_o, irq_empty_o, irq_done_o, serial_out_o, serial_out_oe_n_o, sync_clk_o, sync_clk_oe_n_o;
  logic line, rx_valid, par_en, par_odd, two_stop, ds;
  logic [9:0] rx_word, ex;
  logic [4:0] per;
  logic [3:0] nbits;
  logic [2:0] ctl;
  logic [6:0] fmt [0:7];
  logic [9:0] exp_q[$];
  int errors, comparisons, seed, rnd;

  // Released line is pulled up.
  assign line = serial_out_oe_n_o ? 1'b1 : serial_out_o;

  uart_transmitter uart_transmitter_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .gie_i(gie_i),
    .done_irq_ack_i(done_irq_ack_i), .irq_empty_o(irq_empty_o), .irq_done_o(irq_done_o),
    .serial_out_o(serial_out_o), .serial_out_oe_n_o(serial_out_oe_n_o), .sync_clk_i(sync_clk_i),
    .sync_clk_o(sync_clk_o), .sync_clk_oe_n_o(sync_clk_oe_n_o));
  uart_rx_model uart_rx_model_i (.clk_i(clk_i), .line_i(line), .per_i(per), .nbits_i(nbits), .par_en_i(par_en),
    .par_odd_i(par_odd), .two_stop_i(two_stop), .valid_o(rx_valid), .word_o(rx_word));

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // ========================================================================
  // Tasks
  task automatic finish_test();
    if (exp_q.size() != 0) errors++;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 64);
    if (ack_o !== 1'b1) begin
      errors++;
      finish_test();
    end
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // Polls until the frame is out and the shifter is idle.
  task automatic wait_done();
    int n;
    n = 0;
    do begin
      wb(1'b0, `UTX_CSA_OFS, 32'h0);
      n++;
    end while ((rd[1] !== 1'b1 || rd[3] !== 1'b0) && n < 400);
    if (n >= 400) begin
      errors++;
      finish_test();
    end
  endtask

  task automatic send(input logic [8:0] v);
    wb(1'b1, `UTX_CSB_OFS, {28'h0, v[8], ctl});
    // clear done, zero in empty position
    wb(1'b1, `UTX_CSA_OFS, {29'h0, ds, 2'h2});
    exp_q.push_back({1'b0, v & ~(9'h1ff << nbits)});
    rnd = $random(seed);
    wb(1'b1, `UTX_DATA_OFS, {rnd[31:8], v[7:0]});
  endtask

  // ========================================================================
  // Line results against expectations
  always @(posedge clk_i) begin
    if (rx_valid === 1'b1) begin
      if (exp_q.size() == 0) exp_q.push_back('x);
      ex = exp_q.pop_front();
      `CHK(rx_word, ex)
    end
  end

  initial begin
    repeat (90000) @(posedge clk_i);
    errors++;
    finish_test();
  end

  // ========================================================================
  // Main sequence
  initial begin
    fmt = '{7'h08, 7'h1e, 7'h23, 7'h3d, 7'h7a, 7'h71, 7'h58, 7'h30};
    seed = 32'h5ff3;
    errors = 0;
    comparisons = 0;
    rst_i = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    adr_i = 8'h00;
    sel_i = 4'hf;
    dat_i = 32'h0;
    gie_i = 1'b0;
    done_irq_ack_i = 1'b0;
    sync_clk_i = 1'b0;
    {par_en, par_odd, two_stop, ds} = 4'h0;
    per = 5'h10;
    nbits = 4'h8;
    ctl = 3'h1;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    `CHK({serial_out_oe_n_o, sync_clk_oe_n_o}, 2'h3)
    wb(1'b0, `UTX_CSA_OFS, 32'h0);
    `CHK(rd, 32'h1)
    wb(1'b0, `UTX_CSB_OFS, 32'h0);
    `CHK(rd, 32'h0)
    wb(1'b0, `UTX_CSC_OFS, 32'h0);
    `CHK(rd, 32'h3)
    wb(1'b0, 8'h14, 32'h0);
    `CHK(rd, 32'h0)
    // Buffered while disabled, sent once enabled.
    wb(1'b1, `UTX_DATA_OFS, 32'hffffffa5);
    exp_q.push_back(10'h0a5);
    wb(1'b0, `UTX_CSA_OFS, 32'h0);
    `CHK({rd[0], serial_out_oe_n_o}, 2'h1)
    wb(1'b1, `UTX_CSB_OFS, 32'h1);
    repeat (4) @(posedge clk_i);
    `CHK(serial_out_oe_n_o, 1'b0)
    wait_done();
    `CHK(rd[0], 1'b1)
    wb(1'b1, `UTX_CSA_OFS, 32'h2);
    wb(1'b0, `UTX_CSA_OFS, 32'h0);
    `CHK(rd[1], 1'b0)
    // Eight formats, two characters back to back each.
    for (int i = 0; i < 8; i++) begin
      {par_en, par_odd, two_stop, ds} = fmt[i][3:0];
      nbits = (fmt[i][6:4] == 3'h7) ? 4'h9 : (fmt[i][6:4] > 3'h3) ? 4'h8 : fmt[i][6:4] + 4'h5;
      per = ds ? 5'h08 : 5'h10;
      wb(1'b1, `UTX_CSC_OFS, {25'h0, two_stop, par_odd, par_en, 1'b0, fmt[i][6:4]});
      rnd = $random(seed);
      send(rnd[8:0]);
      send(rnd[17:9]);
      wait_done();
      `CHK(rd[0], 1'b1)
    end
    // Interrupt requests.
    ctl = 3'h7;
    wb(1'b1, `UTX_CSA_OFS, 32'h2);
    wb(1'b1, `UTX_CSB_OFS, 32'h7);
    repeat (4) @(posedge clk_i);
    `CHK(irq_empty_o, 1'b0)
    gie_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    `CHK({irq_empty_o, irq_done_o}, 2'h2)
    send(9'h05a);
    wait_done();
    repeat (2) @(posedge clk_i);
    `CHK({irq_empty_o, irq_done_o}, 2'h3)
    done_irq_ack_i <= 1'b1;
    @(posedge clk_i);
    done_irq_ack_i <= 1'b0;
    wb(1'b0, `UTX_CSA_OFS, 32'h0);
    `CHK({rd[1], irq_done_o}, 2'h0)
    // Delayed disable with a frame pending.
    ctl = 3'h1;
    gie_i <= 1'b0;
    rnd = $random(seed);
    send(rnd[8:0]);
    send(rnd[16:8]);
    wb(1'b1, `UTX_CSB_OFS, 32'h0);
    `CHK(serial_out_oe_n_o, 1'b0)
    wait_done();
    repeat (4) @(posedge clk_i);
    `CHK(serial_out_oe_n_o, 1'b1)
    // Synchronous master frame, two clocks per bit with divisor zero.
    per = 5'h02;
    nbits = 4'h8;
    wb(1'b1, `UTX_CSC_OFS, 32'h183);
    rnd = $random(seed);
    send(rnd[8:0]);
    `CHK(sync_clk_oe_n_o, 1'b0)
    wait_done();
    `CHK(rd[0], 1'b1)
    finish_test();
  end
endmodule // uart_transmitter_bench
